// ===== verilog/bric_core.sv
`default_nettype none
module bric_core
    import bric_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [7:0] byte0,
    input wire logic [7:0] byte1,
    input wire logic [7:0] byte2,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic [15:0] data_pointer,
    input wire logic [7:0] reg_val,
    input wire logic [7:0] ind_val,
    input wire logic [7:0] dir_val,
    input wire logic bit_val,
    output logic busy,
    output logic [1:0] instr_len,
    output logic [2:0] reg_sel,
    output logic [7:0] dir_addr,
    output logic dir_is_sfr,
    output logic [7:0] bit_addr,
    output logic bit_is_sfr,
    output logic [15:0] pc_out,
    output logic pc_load,
    output logic taken,
    output logic [7:0] wb_data,
    output logic wb_reg,
    output logic wb_dir,
    output logic wb_bit_clr,
    output logic call_push
);
    // single-cycle decode; two-cycle forms hold busy one extra cycle
    logic [7:0] op;
    logic is_cmp_reg, is_cmp_ind, is_dec_reg, is_page_j, is_page_c;
    logic [15:0] pc_next, rel_t, page_t, ind_t;
    logic [7:0] dec_src, dec_res, cmp_a, cmp_b, rel_b;
    logic cond, is_cond, is_jump;
    logic [1:0] len;
    logic two_cyc;
    logic [15:0] tgt;
    logic busy_reg;

    assign op = byte0;
    assign is_cmp_reg = op[7:3] == OP_CMP_REG_HI;
    assign is_cmp_ind = op == OP_CMP_IND0 || op == OP_CMP_IND1;
    assign is_dec_reg = op[7:3] == OP_DEC_REG_HI;
    assign is_page_j = op[4:0] == OP_PAGE_JUMP_LO;
    assign is_page_c = op[4:0] == OP_PAGE_CALL_LO;
    assign reg_sel = is_cmp_ind ? {2'b00, op[0]} : op[2:0];
    assign dir_addr = byte1;
    assign dir_is_sfr = byte1[7];
    assign bit_addr = byte1;
    assign bit_is_sfr = byte1[7];

    assign len = (op == OP_NOP || op == OP_JMP_IND) ? 2'd1 :
        (is_cmp_reg || is_cmp_ind || op == OP_CMP_DIR || op == OP_DEC_DIR ||
         op == OP_BIT_SET_CLR || op == OP_BIT_SET || op == OP_BIT_CLR ||
         op == OP_LONG_JUMP || op == OP_LONG_CALL) ? 2'd3 :
        2'd2;
    assign pc_next = pc_in + {14'h0000, len};
    assign rel_b = (len == 2'd3) ? byte2 : byte1;
    assign dec_src = is_dec_reg ? reg_val : dir_val;
    assign dec_res = dec_src - 8'h01;
    assign cmp_a = is_cmp_reg ? reg_val : is_cmp_ind ? ind_val : acc;
    assign cmp_b = (op == OP_CMP_DIR) ? dir_val : byte1;

    always_comb begin
        is_cond = 1'b1;
        cond = 1'b0;
        if (is_cmp_reg || is_cmp_ind || op == OP_CMP_DIR) begin
            cond = cmp_a != cmp_b;
        end else if (is_dec_reg || op == OP_DEC_DIR) begin
            cond = dec_res != 8'h00;
        end else begin
            case (op)
                OP_ACC_ZERO: cond = acc == 8'h00;
                OP_ACC_NONZERO: cond = acc != 8'h00;
                OP_CARRY_SET: cond = carry;
                OP_CARRY_CLR: cond = !carry;
                OP_BIT_SET: cond = bit_val;
                OP_BIT_CLR: cond = !bit_val;
                OP_BIT_SET_CLR: cond = bit_val;
                default: is_cond = 1'b0;
            endcase
        end
    end

    assign is_jump = op == OP_SHORT || op == OP_LONG_JUMP || op == OP_LONG_CALL ||
        op == OP_JMP_IND || is_page_j || is_page_c;

    bric_target u_tgt (
        .pc_next(pc_next),
        .rel(rel_b),
        .full({byte1, byte2}),
        .page({op[7:5], byte1}),
        .acc(acc),
        .data_pointer(data_pointer),
        .rel_target(rel_t),
        .page_target(page_t),
        .ind_target(ind_t)
    );

    always_comb begin
        if (op == OP_LONG_JUMP || op == OP_LONG_CALL) begin
            tgt = {byte1, byte2};
        end else if (is_page_j || is_page_c) begin
            tgt = page_t;
        end else if (op == OP_JMP_IND) begin
            tgt = ind_t;
        end else if ((is_cond && cond) || op == OP_SHORT) begin
            tgt = rel_t;
        end else begin
            tgt = pc_next;
        end
    end

    assign two_cyc = is_cond || is_jump;
    logic busy_next_w;
    assign busy_next_w = instr_valid && !busy_reg && two_cyc;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= busy_next_w;
        end
    end
    assign busy = busy_reg;

    logic go;
    assign go = instr_valid && !busy_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_out <= PC_RESET;
            pc_load <= 1'b0;
            taken <= 1'b0;
            instr_len <= 2'd0;
            wb_data <= 8'h00;
            wb_reg <= 1'b0;
            wb_dir <= 1'b0;
            wb_bit_clr <= 1'b0;
            call_push <= 1'b0;
        end else begin
            pc_load <= go;
            if (go) begin
                pc_out <= tgt;
                instr_len <= len;
                wb_data <= dec_res;
            end
            taken <= go && ((is_cond && cond) || is_jump);
            wb_reg <= go && is_dec_reg;
            wb_dir <= go && op == OP_DEC_DIR;
            wb_bit_clr <= go && op == OP_BIT_SET_CLR && bit_val;
            call_push <= go && (op == OP_LONG_CALL || is_page_c);
        end
    end

    AST_NOP_ONE: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_NOP |=> pc_load && !taken && pc_out == $past(pc_in) + 16'h0001 && !busy)
        else $error("nop did not advance by one");
    AST_CMP_REG: assert property (@(posedge clk) disable iff (!resetn)
        go && is_cmp_reg && reg_val == byte1 |=> pc_out == $past(pc_in) + 16'h0003 && busy)
        else $error("equal compare branched");
    AST_CMP_IND: assert property (@(posedge clk) disable iff (!resetn)
        go && is_cmp_ind |=> taken == ($past(ind_val) != $past(byte1)))
        else $error("indirect compare wrong");
    AST_CMP_DIR: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CMP_DIR |=> taken == ($past(acc) != $past(dir_val)))
        else $error("direct compare wrong");
    AST_DEC_REG: assert property (@(posedge clk) disable iff (!resetn)
        go && is_dec_reg |=> wb_reg && instr_len == 2'd2 && wb_data == $past(reg_val) - 8'h01)
        else $error("register decrement wrong");
    AST_DEC_DIR: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_DEC_DIR && dir_val == 8'h01 |=> wb_dir && !taken ##1 !busy)
        else $error("direct decrement wrong");
    AST_ACC_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_ACC_ZERO |=> taken == ($past(acc) == 8'h00))
        else $error("zero branch wrong");
    AST_CARRY: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CARRY_CLR |=> taken == !$past(carry))
        else $error("carry branch wrong");
    AST_BIT: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_CLR |=> taken == !$past(bit_val))
        else $error("bit branch wrong");
    AST_BIT_SET_CLR: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_SET_CLR && bit_val |=> wb_bit_clr && taken)
        else $error("bit not cleared");
    AST_IND: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_JMP_IND |=> pc_out == $past(data_pointer) + {8'h00, $past(acc)})
        else $error("indirect jump target wrong");
    AST_REL: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_SHORT |=> pc_out == $past(pc_in) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)})
        else $error("relative target wrong");
    AST_LONG: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_LONG_JUMP |=> pc_out == {$past(byte1), $past(byte2)})
        else $error("long target wrong");
    AST_PAGE: assert property (@(posedge clk) disable iff (!resetn)
        go && is_page_j |=> pc_out[15:11] == $past(pc_in + 16'h0002) >> 11)
        else $error("page target left page");
    AST_UNTAKEN: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CARRY_SET && !carry |=> pc_out == $past(pc_in) + 16'h0002)
        else $error("untaken branch wrong");

    AST_CMP_REG_NE: assert property (@(posedge clk) disable iff (!resetn)
        go && is_cmp_reg && reg_val != byte1
        |=> taken && pc_out == $past(pc_in) + 16'h0003 + {{8{$past(byte2[7])}}, $past(byte2)})
        else $error("unequal register compare did not branch");

    AST_CMP_REG_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && is_cmp_reg
        |=> instr_len == 2'd3 && busy ##1 !busy)
        else $error("register compare length or cycles wrong");

    AST_CMP_IND_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && is_cmp_ind
        |=> instr_len == 2'd3 && busy ##1 !busy)
        else $error("indirect compare length or cycles wrong");

    AST_CMP_IND_SEL: assert property (@(posedge clk) disable iff (!resetn)
        is_cmp_ind
        |-> reg_sel == {2'b00, byte0[0]})
        else $error("indirect pointer register select wrong");

    AST_CMP_DIR_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CMP_DIR
        |=> instr_len == 2'd3 && busy)
        else $error("direct compare length wrong");

    AST_DEC_REG_NZ: assert property (@(posedge clk) disable iff (!resetn)
        go && is_dec_reg && reg_val != 8'h01
        |=> taken)
        else $error("register decrement did not branch");

    AST_DEC_REG_Z: assert property (@(posedge clk) disable iff (!resetn)
        go && is_dec_reg && reg_val == 8'h01
        |=> !taken && pc_out == $past(pc_in) + 16'h0002)
        else $error("register decrement to zero branched");

    AST_DEC_DIR_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_DEC_DIR
        |=> instr_len == 2'd3 && wb_dir && wb_data == $past(dir_val) - 8'h01 && busy ##1 !busy)
        else $error("direct decrement length or value wrong");

    AST_DEC_DIR_NZ: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_DEC_DIR && dir_val != 8'h01
        |=> taken)
        else $error("direct decrement did not branch");

    AST_ACC_NONZERO: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_ACC_NONZERO
        |=> taken == ($past(acc) != 8'h00))
        else $error("nonzero branch wrong");

    AST_CARRY_SET: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CARRY_SET
        |=> taken == $past(carry))
        else $error("carry set branch wrong");

    AST_BIT_SET: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_SET
        |=> taken == $past(bit_val))
        else $error("bit set branch wrong");

    AST_BIT_SET_KEEP: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_SET
        |=> !wb_bit_clr)
        else $error("plain bit test cleared the bit");

    AST_BIT_CLR_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        go && op != OP_BIT_SET_CLR
        |=> !wb_bit_clr)
        else $error("bit cleared by another instruction");

    AST_BIT_SET_CLR_IDLE: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_SET_CLR && !bit_val
        |=> !wb_bit_clr && !taken)
        else $error("clear bit branch acted on a zero bit");

    AST_IND_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_JMP_IND
        |=> instr_len == 2'd1 && taken && busy)
        else $error("indirect jump length wrong");

    AST_REL_COND: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_ACC_ZERO && acc == 8'h00
        |=> pc_out == $past(pc_in) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)})
        else $error("two byte branch offset wrong");

    AST_REL_THREE: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_SET && bit_val
        |=> pc_out == $past(pc_in) + 16'h0003 + {{8{$past(byte2[7])}}, $past(byte2)})
        else $error("three byte branch offset wrong");

    AST_LONG_CALL: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_LONG_CALL
        |=> pc_out == {$past(byte1), $past(byte2)} && call_push && instr_len == 2'd3)
        else $error("long call target wrong");

    AST_LONG_LEN: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_LONG_JUMP
        |=> instr_len == 2'd3 && !call_push && taken)
        else $error("long jump length wrong");

    AST_PAGE_LOW: assert property (@(posedge clk) disable iff (!resetn)
        go && is_page_j
        |=> pc_out[10:0] == {$past(byte0[7:5]), $past(byte1)} && instr_len == 2'd2)
        else $error("page jump offset wrong");

    AST_PAGE_CALL: assert property (@(posedge clk) disable iff (!resetn)
        go && is_page_c
        |=> call_push && pc_out[10:0] == {$past(byte0[7:5]), $past(byte1)})
        else $error("page call target wrong");

    AST_DIR_SEL: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid
        |-> dir_addr == byte1 && dir_is_sfr == byte1[7])
        else $error("direct byte select wrong");

    AST_BIT_SEL: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid
        |-> bit_addr == byte1 && bit_is_sfr == byte1[7])
        else $error("bit select wrong");

    AST_UNTAKEN_BIT: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_BIT_CLR && bit_val
        |=> !taken && pc_out == $past(pc_in) + 16'h0003)
        else $error("untaken bit branch wrong");

    AST_UNTAKEN_CMP: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_CMP_DIR && acc == dir_val
        |=> !taken && pc_out == $past(pc_in) + 16'h0003)
        else $error("untaken compare wrong");

    AST_NOP_QUIET: assert property (@(posedge clk) disable iff (!resetn)
        go && op == OP_NOP
        |=> instr_len == 2'd1 && !wb_reg && !wb_dir && !wb_bit_clr && !call_push)
        else $error("nop changed state");

    AST_REFUSED: assert property (@(posedge clk) disable iff (!resetn)
        busy
        |=> !pc_load)
        else $error("request accepted while busy");

    AST_REG_SEL: assert property (@(posedge clk) disable iff (!resetn)
        !is_cmp_ind
        |-> reg_sel == byte0[2:0])
        else $error("bank register select wrong");
endmodule
`default_nettype wire

// ===== verilog/bric_pkg.sv
`default_nettype none
package bric_pkg;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_LONG_JUMP = 8'h02;
    localparam logic [7:0] OP_LONG_CALL = 8'h12;
    localparam logic [7:0] OP_BIT_SET_CLR = 8'h10;
    localparam logic [7:0] OP_BIT_SET = 8'h20;
    localparam logic [7:0] OP_BIT_CLR = 8'h30;
    localparam logic [7:0] OP_CARRY_SET = 8'h40;
    localparam logic [7:0] OP_CARRY_CLR = 8'h50;
    localparam logic [7:0] OP_ACC_ZERO = 8'h60;
    localparam logic [7:0] OP_ACC_NONZERO = 8'h70;
    localparam logic [7:0] OP_JMP_IND = 8'h73;
    localparam logic [7:0] OP_SHORT = 8'h80;
    localparam logic [7:0] OP_CMP_DIR = 8'hB5;
    localparam logic [7:0] OP_CMP_IND0 = 8'hB6;
    localparam logic [7:0] OP_CMP_IND1 = 8'hB7;
    localparam logic [4:0] OP_CMP_REG_HI = 5'h17;
    localparam logic [7:0] OP_DEC_DIR = 8'hD5;
    localparam logic [4:0] OP_DEC_REG_HI = 5'h1B;
    localparam logic [4:0] OP_PAGE_JUMP_LO = 5'h01;
    localparam logic [4:0] OP_PAGE_CALL_LO = 5'h11;
    localparam int PAGE_BITS = 11;
    localparam logic [15:0] PC_RESET = 16'h0000;
    typedef enum logic [2:0] {K_NONE, K_COND, K_JUMP, K_IND} bric_kind_e;
endpackage
`default_nettype wire

// ===== verilog/bric_target.sv
`default_nettype none
module bric_target
    import bric_pkg::*;
(
    input wire logic [15:0] pc_next,
    input wire logic [7:0] rel,
    input wire logic [15:0] full,
    input wire logic [10:0] page,
    input wire logic [7:0] acc,
    input wire logic [15:0] data_pointer,
    output logic [15:0] rel_target,
    output logic [15:0] page_target,
    output logic [15:0] ind_target
);
    assign rel_target = pc_next + {{8{rel[7]}}, rel};
    assign page_target = {pc_next[15:PAGE_BITS], page};
    assign ind_target = data_pointer + {8'h00, acc};
endmodule
`default_nettype wire

// ===== sim/bric_mem.sv
`default_nettype none
module bric_mem
    import bric_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] dir_addr,
    input wire logic [7:0] bit_addr,
    input wire logic [7:0] wb_data,
    input wire logic wb_reg,
    input wire logic wb_dir,
    input wire logic wb_bit_clr,
    output logic [7:0] reg_val,
    output logic [7:0] ind_val,
    output logic [7:0] dir_val,
    output logic bit_val
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [8];
    logic [7:0] ram [256];
    logic [255:0] bits;
    // one flat ram: direct and indirect views alias, so a direct write shows in the indirect view
    assign reg_val = regs[reg_sel];
    assign ind_val = ram[regs[reg_sel]];
    assign dir_val = ram[dir_addr];
    assign bit_val = bits[bit_addr];
    // plain always: the bench preloads these arrays between instructions
    always @(posedge clk) begin
        if (wb_reg) regs[reg_sel] <= wb_data;
        if (wb_dir) ram[dir_addr] <= wb_data;
        if (wb_bit_clr) bits[bit_addr] <= 1'b0;
    end
endmodule
`default_nettype wire

// ===== sim/test_branch_instruction_control.sv
`default_nettype none
module test_branch_instruction_control
    import bric_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, instr_valid, carry, bit_val, busy, dir_is_sfr, bit_is_sfr, pc_load, taken;
    logic wb_reg, wb_dir, wb_bit_clr, call_push;
    logic [7:0] byte0, byte1, byte2, acc, reg_val, ind_val, dir_val, dir_addr, bit_addr, wb_data;
    logic [15:0] pc_in, data_pointer, pc_out;
    logic [2:0] reg_sel;
    logic [1:0] instr_len;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    bric_core uut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .byte0(byte0), .byte1(byte1),
        .byte2(byte2), .pc_in(pc_in), .acc(acc), .carry(carry), .data_pointer(data_pointer), .reg_val(reg_val),
        .ind_val(ind_val), .dir_val(dir_val), .bit_val(bit_val), .busy(busy), .instr_len(instr_len),
        .reg_sel(reg_sel), .dir_addr(dir_addr), .dir_is_sfr(dir_is_sfr), .bit_addr(bit_addr),
        .bit_is_sfr(bit_is_sfr), .pc_out(pc_out), .pc_load(pc_load), .taken(taken), .wb_data(wb_data),
        .wb_reg(wb_reg), .wb_dir(wb_dir), .wb_bit_clr(wb_bit_clr), .call_push(call_push));
    bric_mem m (.clk(clk), .reg_sel(reg_sel), .dir_addr(dir_addr), .bit_addr(bit_addr), .wb_data(wb_data),
        .wb_reg(wb_reg), .wb_dir(wb_dir), .wb_bit_clr(wb_bit_clr), .reg_val(reg_val), .ind_val(ind_val),
        .dir_val(dir_val), .bit_val(bit_val));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic [15:0] rt(input logic [15:0] pc, input logic [1:0] len, input logic [7:0] r);
        return pc + 16'(len) + {{8{r[7]}}, r};
    endfunction
    // tk = x skips the taken flag; unconditional jumps always set taken, and their runs check it with tk = 1
    task automatic run(input logic [7:0] b0, b1, b2, input logic [15:0] pc, input logic [1:0] len,
                       input logic tk, input logic [15:0] tgt, input logic [3:0] wb);
        @(posedge clk);
        #1;
        byte0 = b0;
        byte1 = b1;
        byte2 = b2;
        pc_in = pc;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        chk(pc_load === 1'b1 && instr_len === len && {wb_reg, wb_dir, wb_bit_clr, call_push} === wb, "strobes");
        chk(pc_out === (tk === 1'b0 ? pc + 16'(len) : tgt), "next pc");
        if (tk !== 1'bx) chk(taken === tk, "taken");
        chk(busy === (b0 != OP_NOP), "busy");
        @(posedge clk);
        #1;
        chk(busy === 1'b0 && pc_load === 1'b0, "second cycle");
    endtask
    task automatic t_nop();
        run(OP_NOP, 8'h00, 8'h00, 16'h0010, 2'h1, 1'b0, 16'h0000, 4'h0);
        byte0 = OP_NOP;
        pc_in = 16'h0020;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        pc_in = 16'h0021;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        chk(pc_load === 1'b1 && pc_out === 16'h0022 && busy === 1'b0, "nop pair");
    endtask
    task automatic t_flags();
        acc = 8'h00;
        carry = 1'b1;
        run(OP_ACC_ZERO, 8'h10, 8'h00, 16'h0100, 2'h2, 1'b1, rt(16'h0100, 2'h2, 8'h10), 4'h0);
        run(OP_ACC_NONZERO, 8'h10, 8'h00, 16'h0100, 2'h2, 1'b0, 16'h0000, 4'h0);
        run(OP_CARRY_SET, 8'hF0, 8'h00, 16'h0120, 2'h2, 1'b1, rt(16'h0120, 2'h2, 8'hF0), 4'h0);
        run(OP_CARRY_CLR, 8'hF0, 8'h00, 16'h0120, 2'h2, 1'b0, 16'h0000, 4'h0);
        acc = 8'h01;
        carry = 1'b0;
        run(OP_ACC_ZERO, 8'h10, 8'h00, 16'h0140, 2'h2, 1'b0, 16'h0000, 4'h0);
        run(OP_ACC_NONZERO, 8'hF0, 8'h00, 16'h0140, 2'h2, 1'b1, rt(16'h0140, 2'h2, 8'hF0), 4'h0);
        run(OP_CARRY_SET, 8'h10, 8'h00, 16'h0160, 2'h2, 1'b0, 16'h0000, 4'h0);
        run(OP_CARRY_CLR, 8'h10, 8'h00, 16'h0160, 2'h2, 1'b1, rt(16'h0160, 2'h2, 8'h10), 4'h0);
    endtask
    task automatic t_bits();
        m.bits[8'h85] = 1'b1;
        m.bits[8'h12] = 1'b0;
        run(OP_BIT_SET, 8'h85, 8'h08, 16'h0200, 2'h3, 1'b1, rt(16'h0200, 2'h3, 8'h08), 4'h0);
        chk(bit_addr === 8'h85 && bit_is_sfr === 1'b1, "bit select");
        run(OP_BIT_CLR, 8'h85, 8'h08, 16'h0210, 2'h3, 1'b0, 16'h0000, 4'h0);
        run(OP_BIT_CLR, 8'h12, 8'h08, 16'h0200, 2'h3, 1'b1, rt(16'h0200, 2'h3, 8'h08), 4'h0);
        run(OP_BIT_SET, 8'h12, 8'h08, 16'h0200, 2'h3, 1'b0, 16'h0000, 4'h0);
        run(OP_BIT_SET_CLR, 8'h85, 8'h20, 16'h0220, 2'h3, 1'b1, rt(16'h0220, 2'h3, 8'h20), 4'h2);
        chk(m.bits[8'h85] === 1'b0, "bit not cleared");
    endtask
    task automatic t_cmp();
        m.regs[7] = 8'h55;
        run({OP_CMP_REG_HI, 3'h7}, 8'h55, 8'h05, 16'h0300, 2'h3, 1'b0, 16'h0000, 4'h0);
        run({OP_CMP_REG_HI, 3'h7}, 8'h56, 8'h05, 16'h0300, 2'h3, 1'b1, rt(16'h0300, 2'h3, 8'h05), 4'h0);
        m.regs[1] = 8'h30;
        m.ram[8'h30] = 8'h99;
        run(OP_CMP_IND1, 8'h99, 8'h80, 16'h0320, 2'h3, 1'b0, 16'h0000, 4'h0);
        run(OP_CMP_IND1, 8'h98, 8'h80, 16'h0320, 2'h3, 1'b1, rt(16'h0320, 2'h3, 8'h80), 4'h0);
        chk(reg_sel === 3'h1, "pointer select");
        acc = 8'h3C;
        m.ram[8'h90] = 8'h3C;
        run(OP_CMP_DIR, 8'h90, 8'h7F, 16'h0340, 2'h3, 1'b0, 16'h0000, 4'h0);
        chk(dir_addr === 8'h90 && dir_is_sfr === 1'b1, "direct select");
        m.ram[8'h90] = 8'h00;
        run(OP_CMP_DIR, 8'h90, 8'h7F, 16'h0340, 2'h3, 1'b1, rt(16'h0340, 2'h3, 8'h7F), 4'h0);
    endtask
    task automatic t_dec();
        m.regs[2] = 8'h01;
        run({OP_DEC_REG_HI, 3'h2}, 8'h20, 8'h00, 16'h0400, 2'h2, 1'b0, 16'h0000, 4'h8);
        chk(wb_data === 8'h00 && m.regs[2] === 8'h00, "dec to zero");
        run({OP_DEC_REG_HI, 3'h2}, 8'h20, 8'h00, 16'h0400, 2'h2, 1'b1, rt(16'h0400, 2'h2, 8'h20), 4'h8);
        chk(wb_data === 8'hFF, "dec wrap");
        m.ram[8'h40] = 8'h02;
        run(OP_DEC_DIR, 8'h40, 8'hFE, 16'h0420, 2'h3, 1'b1, rt(16'h0420, 2'h3, 8'hFE), 4'h4);
        chk(m.ram[8'h40] === 8'h01, "dec direct");
        m.ram[8'h41] = 8'h01;
        run(OP_DEC_DIR, 8'h41, 8'h10, 16'h0440, 2'h3, 1'b0, 16'h0000, 4'h4);
        chk(m.ram[8'h41] === 8'h00, "dec direct to zero");
    endtask
    task automatic t_jumps();
        run(OP_SHORT, 8'hFE, 8'h00, 16'h0100, 2'h2, 1'b1, 16'h0100, 4'h0);
        run(OP_LONG_JUMP, 8'hAB, 8'hCD, 16'h0500, 2'h3, 1'b1, 16'hABCD, 4'h0);
        run(OP_LONG_CALL, 8'hFF, 8'hFE, 16'h0520, 2'h3, 1'b1, 16'hFFFE, 4'h1);
        run({3'h5, OP_PAGE_JUMP_LO}, 8'h34, 8'h00, 16'h07FE, 2'h2, 1'b1, 16'h0D34, 4'h0);
        run({3'h7, OP_PAGE_CALL_LO}, 8'h01, 8'h00, 16'h1000, 2'h2, 1'b1, 16'h1701, 4'h1);
        acc = 8'hF0;
        data_pointer = 16'hFF20;
        run(OP_JMP_IND, 8'h00, 8'h00, 16'h0600, 2'h1, 1'b1, 16'h0010, 4'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        {resetn, instr_valid, carry, byte0, byte1, byte2, acc, pc_in, data_pointer} = '0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk(pc_out === PC_RESET && busy === 1'b0 && pc_load === 1'b0, "reset state");
        t_nop();
        t_flags();
        t_bits();
        t_cmp();
        t_dec();
        t_jumps();
        print_verdict();
    end
endmodule
`default_nettype wire
